//--- hw/i2c_slave_control_port.sv
// two-wire slave port that writes the regulator control registers
// Notes on behaviour
// - slave only; same protocol at 100 kbps and 400 kbps
// - seven-bit addressing only; no ten-bit, no general call
// - address upper bits fixed, two low bits from strap pin
// - ground gives 0x60; open and high give 0x61 and 0x62
// - both lines driven only through open-drain, never high
// - lines released while the bus is idle
// - registers hold their values while supply stays up
// - acknowledge own write address and each byte after it by holding data low
// - data applied on falling clock ending the last data bit
// - both enable pins low ignores bus; otherwise fully working
`timescale 1ns/1ns
module i2c_slave_control_port
    import i2c_port_pkg::*;
#(
    parameter int REGS = REG_COUNT
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic             sclOut,
    output logic             sclOe,
    input  wire logic        strapLow,
    input  wire logic        strapHigh,
    input  wire logic        buck_one_enable_pin,
    input  wire logic        buck_two_enable_pin,
    output logic [8*REGS-1:0] regBank,
    output logic             regWriteStrobe
);
    typedef enum logic [4:0] {
        IDLE  = 5'b00001,
        ADDR  = 5'b00010,
        REGAD = 5'b00100,
        DATA  = 5'b01000,
        SKIP  = 5'b10000
    } state_e;

    // two-flop synchronisers; stage one read only by stage two
    logic [1:0] sclSync, sdaSync, lowSync, highSync, en1Sync, en2Sync;
    logic       sclD, sdaD;
    always_ff @(posedge clk) begin
        if (srst) begin
            sclSync  <= 2'h3;
            sdaSync  <= 2'h3;
            lowSync  <= 2'h0;
            highSync <= 2'h0;
            en1Sync  <= 2'h0;
            en2Sync  <= 2'h0;
            sclD     <= 1'b1;
            sdaD     <= 1'b1;
        end else begin
            sclSync  <= {sclSync[0], sclIn};
            sdaSync  <= {sdaSync[0], sdaIn};
            lowSync  <= {lowSync[0], strapLow};
            highSync <= {highSync[0], strapHigh};
            en1Sync  <= {en1Sync[0], buck_one_enable_pin};
            en2Sync  <= {en2Sync[0], buck_two_enable_pin};
            sclD     <= sclSync[1];
            sdaD     <= sdaSync[1];
        end
    end

    logic scl, sda, sclRise, sclFall, startCond, stopCond, portOn;
    assign scl       = sclSync[1];
    assign sda       = sdaSync[1];
    assign sclRise   = scl & ~sclD;
    assign sclFall   = ~scl & sclD;
    assign startCond = scl & sclD & sdaD & ~sda;
    assign stopCond  = scl & sclD & ~sdaD & sda;
    // hardware shutdown only when both enable pins low
    assign portOn    = en1Sync[1] | en2Sync[1];

    // strap decode; open strap reads neither low nor high
    function automatic logic [6:0] slaveAddr(input logic lo,
                                             input logic hi);
        logic [1:0] low2;
        if (lo)
            low2 = STRAP_LOW_GND;
        else if (hi)
            low2 = STRAP_LOW_HIGH;
        else
            low2 = STRAP_LOW_OPEN;
        return {ADDR_UPPER, low2};
    endfunction

    // strap resampled on every clock edge, not loaded by the reset
    logic [6:0] myAddr;
    always_ff @(posedge clk) begin
        myAddr <= slaveAddr(lowSync[1], highSync[1]);
    end

    state_e     state;
    logic [2:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] regPtr;
    logic       ackPhase;
    logic       ackDrive;
    logic       lastData;
    logic       byteFull;
    logic [7:0] next_shift;
    assign next_shift = {shiftReg[6:0], sda};

    // byte receiver; same edge logic serves either bus rate
    always_ff @(posedge clk) begin
        if (srst || !portOn) begin
            state    <= IDLE;
            bitCnt   <= 3'h0;
            shiftReg <= 8'h00;
            regPtr   <= 8'h00;
            ackPhase <= 1'b0;
            ackDrive <= 1'b0;
            lastData <= 1'b0;
            byteFull <= 1'b0;
        end else if (startCond) begin
            state    <= ADDR;
            bitCnt   <= 3'h0;
            ackPhase <= 1'b0;
            ackDrive <= 1'b0;
            lastData <= 1'b0;
            byteFull <= 1'b0;
        end else if (stopCond) begin
            state    <= IDLE;
            ackPhase <= 1'b0;
            ackDrive <= 1'b0;
        end else if (state != IDLE && state != SKIP) begin
            lastData <= 1'b0;
            // bits counted on rises, so the fall right after start is no bit
            if (sclRise && !ackPhase) begin
                shiftReg <= next_shift;
                bitCnt   <= bitCnt + 3'h1;
                byteFull <= (bitCnt == BIT_LAST);
            end
            if (sclFall) begin
                if (ackPhase) begin
                    // ack clock ends; release line
                    ackPhase <= 1'b0;
                    ackDrive <= 1'b0;
                end else if (byteFull) begin
                    byteFull <= 1'b0;
                    ackPhase <= 1'b1;
                    unique case (state)
                        ADDR: begin
                            // write to own address only; reads unsupported
                            if (shiftReg[7:1] == myAddr
                                && !shiftReg[0]) begin
                                ackDrive <= 1'b1;
                                state    <= REGAD;
                            end else begin
                                ackPhase <= 1'b0;
                                state    <= SKIP;
                            end
                        end
                        REGAD: begin
                            regPtr   <= shiftReg;
                            ackDrive <= 1'b1;
                            state    <= DATA;
                        end
                        DATA: begin
                            ackDrive <= 1'b1;
                            lastData <= 1'b1;
                        end
                        default: state <= SKIP;
                    endcase
                end
            end
        end
    end

    // register bank; only reset clears it, so values hold with supply
    always_ff @(posedge clk) begin
        if (srst) begin
            regBank        <= {REGS{REG_RESET}};
            regWriteStrobe <= 1'b0;
        end else begin
            regWriteStrobe <= 1'b0;
            for (int i = 0; i < REGS; i++) begin
                if (lastData && regPtr == 8'(i)) begin
                    regBank[8*i +: 8] <= shiftReg;
                    regWriteStrobe    <= 1'b1;
                end
            end
        end
    end

    // open-drain: only ever pull low, clock never driven
    always_ff @(posedge clk) begin
        if (srst) begin
            sdaOut <= 1'b0;
            sdaOe  <= 1'b0;
            sclOut <= 1'b0;
            sclOe  <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            sdaOe  <= ackDrive && portOn && !stopCond;
            sclOut <= 1'b0;
            sclOe  <= 1'b0;
        end
    end

    chk_never_drive_high: assert property (@(posedge clk) disable iff (srst)
        !(sdaOe && sdaOut) && !sclOe)
        else $error("line driven high");
    chk_idle_released: assert property (@(posedge clk) disable iff (srst)
        (state == IDLE && !ackDrive) |=> !sdaOe)
        else $error("line held while idle");
    chk_skip_released: assert property (@(posedge clk) disable iff (srst)
        (state == SKIP) |-> ##1 !sdaOe)
        else $error("drove bus for other address");
    chk_shutdown_quiet: assert property (@(posedge clk) disable iff (srst)
        !portOn |=> (state == IDLE && !lastData))
        else $error("port active in shutdown");
    chk_write_strobe: assert property (@(posedge clk) disable iff (srst)
        lastData && regPtr < 8'(REGS) |=> regWriteStrobe)
        else $error("data byte not applied");
    chk_ack_follows: assert property (@(posedge clk) disable iff (srst)
        $rose(ackDrive) && portOn |=> sdaOe)
        else $error("ack not driven");
    chk_addr_match: assert property (@(posedge clk) disable iff (srst)
        (state == ADDR && $past(state) == ADDR) ##1 state == REGAD
        |-> $past(shiftReg[7:1], 2) == myAddr)
        else $error("wrong address accepted");
    chk_bank_holds: assert property (@(posedge clk) disable iff (srst)
        !lastData |=> $stable(regBank))
        else $error("register changed without write");
endmodule

//--- hw/i2c_port_pkg.sv
// shared constants for the two-wire slave control port
package i2c_port_pkg;
    // fixed upper five bits of the seven-bit slave address
    localparam logic [4:0] ADDR_UPPER     = 5'h18;
    // low two bits per strap state
    localparam logic [1:0] STRAP_LOW_GND  = 2'h0;
    localparam logic [1:0] STRAP_LOW_OPEN = 2'h1;
    localparam logic [1:0] STRAP_LOW_HIGH = 2'h2;
    // register file shape and reset value
    localparam int         REG_COUNT      = 5;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [2:0] BIT_LAST       = 3'h7;
endpackage

//--- tb/i2c_bus_master.sv
// bus master model driving the two-wire lines
`timescale 1ns/1ns
module i2c_bus_master (
    input  wire logic clk,
    input  wire logic sdaOe,
    output logic      scl,
    output logic      sda
);
    logic pull;
    // open drain on both sides, pull-up wins when idle
    assign sda = !(pull || sdaOe);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // a quarter of the 160 ns bit, changed on falling clk
    task automatic q;
        repeat (2) @(negedge clk);
    endtask
    // start, msb-first bytes, stop all made here
    task automatic xfer(input logic [23:0] b, output logic [2:0] ack);
        pull = 1'b1;
        q();
        scl = 1'b0;
        q();
        for (int i = 23; i >= 0; i--) begin
            pull = !b[i];
            q();
            scl = 1'b1;
            q();
            q();
            scl = 1'b0;
            q();
            if (i % 8 == 0) begin
                // extra low time, slave answers some clocks late
                pull = 1'b0;
                q();
                q();
                scl = 1'b1;
                q();
                ack[i/8] = !sda;
                q();
                scl = 1'b0;
                q();
                q();
            end
        end
        pull = 1'b1;
        q();
        scl = 1'b1;
        q();
        pull = 1'b0;
        q();
    endtask
endmodule

//--- tb/i2c_slave_control_port_tb.sv
// self-checking bench for the two-wire slave control port
`timescale 1ns/1ns
module i2c_slave_control_port_tb;
    import i2c_port_pkg::*;
    logic        clk, srst, strapLow, strapHigh, enA, enB, scl, sda;
    logic        sdaOut, sdaOe, sclOut, sclOe, regWriteStrobe;
    logic [39:0] regBank, expBank;
    logic [2:0]  ack;
    int          failures, cmp_count, cycles, seed, strobes;
    i2c_slave_control_port u_i2c_slave_control_port (.clk(clk),
        .srst(srst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
        .strapLow(strapLow), .strapHigh(strapHigh),
        .buck_one_enable_pin(enA), .buck_two_enable_pin(enB),
        .regBank(regBank), .regWriteStrobe(regWriteStrobe));
    i2c_bus_master u_i2c_bus_master (.clk(clk), .sdaOe(sdaOe),
        .scl(scl), .sda(sda));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one write transfer, then compare with the reference bank
    task automatic wr(input logic [6:0] a, input logic [7:0] r,
                      input logic [2:0] want);
        int   s;
        logic [7:0] d;
        logic w;
        s = strobes;
        d = 8'($random(seed));
        u_i2c_bus_master.xfer({a, 1'b0, r, d}, ack);
        repeat (8) @(negedge clk);
        w = (want == 3'b111) && (r < REG_COUNT);
        if (w)
            expBank[8*r +: 8] = d;
        check(40'(ack), 40'(want));
        check(regBank, expBank);
        check(40'(strobes - s), 40'(w));
        check(40'({sdaOut, sdaOe, sclOe, sclOut}), '0);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        strobes += (regWriteStrobe === 1'b1);
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        seed = 32'h416f_fba0;
        {srst, strapLow, strapHigh, enA, enB} = 5'b1_1010;
        expBank = '0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (8) @(negedge clk);
        check(regBank, expBank);
        // every strap state, right then wrong address
        for (int k = 0; k < 3; k++) begin
            {strapLow, strapHigh} = (k == 0) ? 2'b10 : {1'b0, k == 2};
            repeat (4) @(negedge clk);
            wr(7'h60 + 7'(k), 8'($unsigned($random(seed)) % 5),
               3'b111);
            wr(7'h60 + 7'((k + 1) % 3), 8'h01, 3'b000);
        end
        wr(7'h00, 8'h00, 3'b000);
        wr(7'h62, 8'h05, 3'b111);
        wr(7'h62, 8'h02, 3'b111);
        // read direction is refused: no ack, nothing written
        u_i2c_bus_master.xfer({7'h62, 1'b1, 16'h0301}, ack);
        repeat (8) @(negedge clk);
        check(40'(ack), 40'h0);
        check(regBank, expBank);
        // enables pass two flops, so let them settle before a start
        {enA, enB} = 2'b00;
        repeat (4) @(negedge clk);
        wr(7'h62, 8'h03, 3'b000);
        enB = 1'b1;
        repeat (4) @(negedge clk);
        wr(7'h62, 8'h04, 3'b111);
        finish_test();
    end
endmodule
